// [pkg/csss_pkg.sv]
package csss_pkg;

	// Register byte addresses on the AXI4-Lite bus.
	localparam logic [3:0] ADDR_TRIM   = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam int         ADDR_W      = 4;

	// AXI response codes.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Clock source select codes, in raw fuse polarity (one means unprogrammed).
	localparam logic [3:0] SEL_EXT_CLOCK  = 4'h0;
	localparam logic [3:0] SEL_INT_RC_LO  = 4'h1;
	localparam logic [3:0] SEL_INT_RC_HI  = 4'h4;
	localparam logic [3:0] SEL_EXT_RC_LO  = 4'h5;
	localparam logic [3:0] SEL_EXT_RC_HI  = 4'h8;
	localparam logic [3:0] SEL_LF_CRYSTAL = 4'h9;

	// Start-up time fuse codes.
	localparam logic [1:0] SUT_00 = 2'h0;
	localparam logic [1:0] SUT_01 = 2'h1;
	localparam logic [1:0] SUT_10 = 2'h2;
	localparam logic [1:0] SUT_11 = 2'h3;

	// Wake start-up lengths in cycles of the selected source.
	localparam int          CNT_W     = 17;
	localparam logic [16:0] WAKE_6    = 17'h00006;
	localparam logic [16:0] WAKE_18   = 17'h00012;
	localparam logic [16:0] WAKE_1K   = 17'h00400;
	localparam logic [16:0] WAKE_32K  = 17'h08000;
	localparam logic [16:0] CNT_ONE   = 17'h00001;
	localparam logic [16:0] CNT_ZERO  = 17'h00000;

	// Reset delay defaults in watchdog oscillator cycles (4.1 ms and 65 ms).
	localparam int RST_DELAY_SHORT_DEF = 4096;
	localparam int RST_DELAY_LONG_DEF  = 65536;

	// Status register field positions.
	localparam int ST_KIND_LSB   = 0;
	localparam int ST_BAND_LSB   = 3;
	localparam int ST_RUN_BIT    = 5;
	localparam int ST_PHASE_LSB  = 6;
	localparam int ST_SEL_LSB    = 8;
	localparam int ST_SUT_LSB    = 12;
	localparam int ST_OPT_BIT    = 14;
	localparam int ST_OPTERR_BIT = 15;

	typedef enum logic [2:0] {
		KIND_EXT_CLOCK,
		KIND_INT_RC,
		KIND_EXT_RC,
		KIND_LF_CRYSTAL,
		KIND_CRYSTAL
	} csss_kind_e;

	typedef enum logic [1:0] {
		DLY_NONE,
		DLY_SHORT,
		DLY_LONG
	} csss_dly_e;

	typedef struct packed {
		logic [3:0] clock_source_select_fuses;
		logic [1:0] startup_time_fuses;
		logic       oscillator_option_fuse;
	} csss_fuse_s;

	typedef struct packed {
		csss_kind_e kind;
		logic [1:0] band;
		logic [7:0] trim_value;
	} csss_clk_s;

endpackage : csss_pkg

// [rtl/csss_top.sv]
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

// Contract
// - Fuse code 1001 selects low-frequency crystal.
// - Low-frequency crystal start-up and reset delay table.
// - Codes 0101 to 1000 are external RC bands.
// - External RC start-up and reset delay table.
// - Codes 0001 to 0100 select internal RC frequencies.
// - Internal RC start-up and reset delay table.
// - Reset loads factory calibration into trim register.
// - Reset delay always timed by watchdog oscillator.
// - Trim zero slowest, all ones fastest, monotonic.
// - Nonvolatile memory timing follows calibrated oscillator.
// - Fuse code 0000 selects external clock pin.
// - External clock start-up and reset delay table.
// - Wake counts selected source cycles before resuming.
// - Reset delays are 4096 and 65536 watchdog cycles.
// - Fuse bit one means unprogrammed; decode accordingly.
module csss_top
	import csss_pkg::*;
#(
	parameter int RST_DELAY_SHORT = csss_pkg::RST_DELAY_SHORT_DEF,
	parameter int RST_DELAY_LONG  = csss_pkg::RST_DELAY_LONG_DEF
) (
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [csss_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	output logic [1:0]                      s_axi_bresp,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	input  wire logic [csss_pkg::ADDR_W-1:0] s_axi_araddr,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	input  wire csss_pkg::csss_fuse_s       fuses,
	input  wire logic [7:0]                 factory_calibration,
	input  wire logic                       wdt_osc_tick,
	input  wire logic                       src_osc_tick,
	input  wire logic                       rc_osc_tick,
	input  wire logic                       deep_sleep,
	input  wire logic                       wake_event,
	output csss_pkg::csss_clk_s             clk_select,
	output logic                            core_clock_en,
	output logic                            nvm_timing_tick
);
	import csss_pkg::*;

	typedef enum logic [1:0] {
		PH_SRC_COUNT,
		PH_RST_DELAY,
		PH_RUN,
		PH_SLEEP
	} csss_phase_e;

	localparam logic [16:0] DLY_SHORT_CNT = RST_DELAY_SHORT[16:0];
	localparam logic [16:0] DLY_LONG_CNT  = 17'(RST_DELAY_LONG);

	csss_fuse_s         fuse_q;
	csss_fuse_s         next_fuse_q;
	csss_kind_e         dec_kind;
	logic [1:0]         dec_band;
	logic [CNT_W-1:0]   dec_wake;
	csss_dly_e          dec_dly;
	logic [CNT_W-1:0]   dly_target;
	csss_phase_e        phase;
	csss_phase_e        next_phase;
	logic [CNT_W-1:0]   count;
	logic [CNT_W-1:0]   next_count;
	logic [7:0]         trim;
	logic [7:0]         next_trim;
	logic               opt_err;
	logic               nvm_tick_q;
	logic               next_nvm_tick_q;
	logic               aw_got, next_aw_got;
	logic               w_got, next_w_got;
	logic [ADDR_W-1:0]  aw_addr, next_aw_addr;
	logic [31:0]        w_data, next_w_data;
	logic [3:0]         w_strb, next_w_strb;
	logic               bvalid, next_bvalid;
	logic [1:0]         bresp, next_bresp;
	logic               rvalid, next_rvalid;
	logic [31:0]        rdata, next_rdata;
	logic [1:0]         rresp, next_rresp;
	logic               wake_path, next_wake_path;
	logic               do_write;
	logic [31:0]        status_word;

	// Fuses are sampled while reset is held, so a change applied with reset asserted
	// takes effect cleanly at release and cannot disturb a running sequence.
	always_comb begin
		next_fuse_q = fuse_q;
		if (!aresetn) begin
			next_fuse_q = fuses;
		end
	end

	always_ff @(posedge aclk) begin
		fuse_q <= next_fuse_q;
	end

	// Source and start-up decode; codes are compared in raw fuse polarity.
	always_comb begin
		dec_kind = KIND_CRYSTAL;
		dec_band = 2'h0;
		dec_wake = WAKE_32K;
		dec_dly  = DLY_LONG;
		if (fuse_q.clock_source_select_fuses == SEL_LF_CRYSTAL) begin
			dec_kind = KIND_LF_CRYSTAL;
			// Reserved code 11 falls through to the long settings of code 10.
			dec_wake = (fuse_q.startup_time_fuses < SUT_10) ? WAKE_1K : WAKE_32K;
			dec_dly  = (fuse_q.startup_time_fuses == SUT_00) ? DLY_SHORT : DLY_LONG;
		end else if (fuse_q.clock_source_select_fuses >= SEL_EXT_RC_LO &&
			fuse_q.clock_source_select_fuses <= SEL_EXT_RC_HI) begin
			dec_kind = KIND_EXT_RC;
			dec_band = 2'(fuse_q.clock_source_select_fuses - SEL_EXT_RC_LO);
			dec_wake = (fuse_q.startup_time_fuses == SUT_11) ? WAKE_6 : WAKE_18;
			unique case (fuse_q.startup_time_fuses)
				SUT_00:         dec_dly = DLY_NONE;
				SUT_01, SUT_11: dec_dly = DLY_SHORT;
				SUT_10:         dec_dly = DLY_LONG;
			endcase
		end else if (fuse_q.clock_source_select_fuses >= SEL_INT_RC_LO &&
			fuse_q.clock_source_select_fuses <= SEL_INT_RC_HI) begin
			dec_kind = KIND_INT_RC;
			dec_band = 2'(fuse_q.clock_source_select_fuses - SEL_INT_RC_LO);
			dec_wake = WAKE_6;
			unique case (fuse_q.startup_time_fuses)
				SUT_00:         dec_dly = DLY_NONE;
				SUT_01:         dec_dly = DLY_SHORT;
				SUT_10, SUT_11: dec_dly = DLY_LONG;
			endcase
		end else if (fuse_q.clock_source_select_fuses == SEL_EXT_CLOCK) begin
			dec_kind = KIND_EXT_CLOCK;
			dec_wake = WAKE_6;
			unique case (fuse_q.startup_time_fuses)
				SUT_00:         dec_dly = DLY_NONE;
				SUT_01:         dec_dly = DLY_SHORT;
				SUT_10, SUT_11: dec_dly = DLY_LONG;
			endcase
		end
	end

	// Reset delay length in watchdog oscillator cycles.
	always_comb begin
		unique case (dec_dly)
			DLY_NONE:  dly_target = CNT_ZERO;
			DLY_SHORT: dly_target = DLY_SHORT_CNT;
			default:   dly_target = DLY_LONG_CNT;
		endcase
	end

	// Start-up sequencer. After reset the source cycles are counted first, then the
	// watchdog-timed delay; a wake from deep sleep counts source cycles only.
	always_comb begin
		next_phase     = phase;
		next_count     = count;
		next_wake_path = wake_path;
		unique case (phase)
			PH_SRC_COUNT: begin
				if (src_osc_tick) begin
					next_count = count + CNT_ONE;
					if (next_count >= dec_wake) begin
						next_count = CNT_ZERO;
						// A wake skips the watchdog delay, which belongs to reset only.
						next_phase = wake_path ? PH_RUN : PH_RST_DELAY;
					end
				end
			end
			PH_RST_DELAY: begin
				if (dly_target == CNT_ZERO) begin
					next_phase = PH_RUN;
				end else if (wdt_osc_tick) begin
					next_count = count + CNT_ONE;
					if (next_count >= dly_target) begin
						next_count = CNT_ZERO;
						next_phase = PH_RUN;
					end
				end
			end
			PH_RUN: begin
				next_count     = CNT_ZERO;
				next_wake_path = 1'b0;
				if (deep_sleep) begin
					next_phase = PH_SLEEP;
				end
			end
			PH_SLEEP: begin
				next_count = CNT_ZERO;
				if (wake_event) begin
					next_phase     = PH_SRC_COUNT;
					next_wake_path = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase     <= PH_SRC_COUNT;
			count     <= CNT_ZERO;
			wake_path <= 1'b0;
		end else begin
			phase     <= next_phase;
			count     <= next_count;
			wake_path <= next_wake_path;
		end
	end

	// Trim register: reloaded from the factory byte on every reset, otherwise written
	// by software byte lane zero. A larger value means a faster internal oscillator.
	always_comb begin
		next_trim = trim;
		if (!aresetn) begin
			next_trim = factory_calibration;
		end else if (do_write && aw_addr == ADDR_TRIM && w_strb[0]) begin
			next_trim = w_data[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		trim <= next_trim;
	end

	// Nonvolatile memory timing is a registered copy of the trimmed oscillator tick.
	always_comb begin
		next_nvm_tick_q = aresetn && rc_osc_tick;
	end

	always_ff @(posedge aclk) begin
		nvm_tick_q <= next_nvm_tick_q;
	end

	// Flag a programmed option fuse while the internal oscillator is chosen.
	assign opt_err = (dec_kind == KIND_INT_RC) && !fuse_q.oscillator_option_fuse;

	assign clk_select = '{kind: dec_kind, band: dec_band, trim_value: trim};
	assign core_clock_en         = (phase == PH_RUN);
	assign nvm_timing_tick       = nvm_tick_q;

	assign status_word = {16'h0000,
		opt_err,
		fuse_q.oscillator_option_fuse,
		fuse_q.startup_time_fuses,
		fuse_q.clock_source_select_fuses,
		phase,
		core_clock_en,
		dec_band,
		dec_kind};

	// AXI write channel: address and data are taken in either order and the write
	// happens once both are held, answered one cycle later.
	assign s_axi_awready = !aw_got && !bvalid;
	assign s_axi_wready  = !w_got && !bvalid;
	assign do_write      = aw_got && w_got && !bvalid;

	always_comb begin
		next_aw_got  = aw_got;
		next_w_got   = w_got;
		next_aw_addr = aw_addr;
		next_w_data  = w_data;
		next_w_strb  = w_strb;
		next_bvalid  = bvalid;
		next_bresp   = bresp;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_got  = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_got  = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (do_write) begin
			next_aw_got = 1'b0;
			next_w_got  = 1'b0;
			next_bvalid = 1'b1;
			next_bresp  = (aw_addr == ADDR_TRIM) ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got  <= 1'b0;
			w_got   <= 1'b0;
			aw_addr <= '0;
			w_data  <= 32'h00000000;
			w_strb  <= 4'h0;
			bvalid  <= 1'b0;
			bresp   <= RESP_OKAY;
		end else begin
			aw_got  <= next_aw_got;
			w_got   <= next_w_got;
			aw_addr <= next_aw_addr;
			w_data  <= next_w_data;
			w_strb  <= next_w_strb;
			bvalid  <= next_bvalid;
			bresp   <= next_bresp;
		end
	end

	assign s_axi_bvalid = bvalid;
	assign s_axi_bresp  = bresp;

	// AXI read channel: one read at a time, data registered on acceptance.
	assign s_axi_arready = !rvalid;

	always_comb begin
		next_rvalid = rvalid;
		next_rdata  = rdata;
		next_rresp  = rresp;
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp  = RESP_OKAY;
			if (s_axi_araddr == ADDR_TRIM) begin
				next_rdata = {24'h000000, trim};
			end else if (s_axi_araddr == ADDR_STATUS) begin
				next_rdata = status_word;
			end else begin
				next_rdata = 32'h00000000;
				next_rresp = RESP_SLVERR;
			end
		end else if (rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h00000000;
			rresp  <= RESP_OKAY;
		end else begin
			rvalid <= next_rvalid;
			rdata  <= next_rdata;
			rresp  <= next_rresp;
		end
	end

	assign s_axi_rvalid = rvalid;
	assign s_axi_rdata  = rdata;
	assign s_axi_rresp  = rresp;

endmodule : csss_top

`default_nettype wire

// [testbench/clock_source_startup_select_tb.sv]
`timescale 1ns/1ns
`default_nettype none

module clock_source_startup_select_tb;
	import csss_pkg::*;

	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, src_t, wdt_t, rc_t;
	logic        deep_sleep, wake_event, core_clock_en, nvm_timing_tick;
	logic [3:0]  awaddr, araddr, sp;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	logic [7:0]  cal;
	csss_fuse_s  fuses;
	csss_clk_s   clk_select;
	int          err_count, n_tests;

	// Short reset delays of 8 and 16 watchdog ticks keep the run brief.
	csss_top #(.RST_DELAY_SHORT(8), .RST_DELAY_LONG(16)) dut_u (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.fuses(fuses), .factory_calibration(cal), .wdt_osc_tick(wdt_t), .src_osc_tick(src_t),
		.rc_osc_tick(rc_t), .deep_sleep(deep_sleep), .wake_event(wake_event),
		.clk_select(clk_select), .core_clock_en(core_clock_en), .nvm_timing_tick(nvm_timing_tick));

	csss_src_model src_u (.aclk(aclk), .aresetn(aresetn), .sp(sp), .src_osc_tick(src_t),
		.wdt_osc_tick(wdt_t), .rc_osc_tick(rc_t));

	// Clock of 50 ns period.
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk

	task results;
		$display("tests %0d errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : results

	// Ready and valid are read 1 ns after an edge, when they are settled for the next edge.
	task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ao, wo, bo;
		int   t;
		ao = 1'b0;
		wo = 1'b0;
		bo = 1'b0;
		t = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!bo && t < 100) begin
			#1;
			ao = ao | (awvalid & awready);
			wo = wo | (wvalid & wready);
			bo = bvalid;
			if (bo) chk(bresp, er);
			@(posedge aclk);
			if (ao) awvalid <= 1'b0;
			if (wo) wvalid <= 1'b0;
			if (bo) bready <= 1'b0;
			t++;
		end
		if (!bo) chk(t, 0);
	endtask : axw

	task automatic axr(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic ao, ro;
		int   t;
		ao = 1'b0;
		ro = 1'b0;
		t = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!ro && t < 100) begin
			#1;
			ao = ao | (arvalid & arready);
			ro = rvalid;
			if (ro) chk(rdata, ed);
			if (ro) chk(rresp, er);
			@(posedge aclk);
			if (ao) arvalid <= 1'b0;
			if (ro) rready <= 1'b0;
			t++;
		end
		if (!ro) chk(t, 0);
	endtask : axr

	// Cycles until the core runs must match the expected count within a tick or two.
	task automatic meas(input int e);
		int c;
		c = 0;
		while (core_clock_en !== 1'b1 && c < e + 20) begin
			@(posedge aclk);
			#1;
			c++;
		end
		chk((c + 2 >= e && c <= e + 2) ? e : c, e);
	endtask : meas

	// Fuses and source rate change only inside reset; the option fuse stays unprogrammed.
	task automatic boot(input logic [3:0] s, input logic [1:0] u, input int w, input int dl,
		input logic [3:0] p, input logic [2:0] ek, input logic [1:0] eb);
		@(posedge aclk);
		aresetn <= 1'b0;
		fuses <= '{s, u, 1'b1};
		sp <= p;
		cal <= {4'ha, s};
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		meas(w * p + dl * 3);
		chk(clk_select.trim_value, {4'ha, s});
		chk(clk_select.kind, ek);
		if (ek == 3'h1 || ek == 3'h2) chk(clk_select.band, eb);
	endtask : boot

	// A wake counts source cycles only, with no watchdog delay.
	task automatic wake(input int e);
		@(posedge aclk);
		deep_sleep <= 1'b1;
		@(posedge aclk);
		deep_sleep <= 1'b0;
		repeat (3) @(posedge aclk);
		#1 chk(core_clock_en, 1'b0);
		@(posedge aclk);
		wake_event <= 1'b1;
		@(posedge aclk);
		wake_event <= 1'b0;
		meas(e);
	endtask : wake

	// Watchdog sized well above the roughly 69000 cycles of the sequence.
	initial begin
		#(90000 * 50);
		err_count++;
		results();
	end

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, deep_sleep, wake_event} <= 8'h00;
		{awaddr, araddr, wdata} <= 40'h0;
		err_count = 0;
		n_tests = 0;
		boot(4'h0, 2'h0, 6, 0, 2, 3'h0, 2'h0);
		boot(4'h0, 2'h1, 6, 8, 2, 3'h0, 2'h0);
		boot(4'h0, 2'h2, 6, 16, 2, 3'h0, 2'h0);
		boot(4'h0, 2'h3, 6, 16, 2, 3'h0, 2'h0);
		boot(4'h2, 2'h0, 6, 0, 2, 3'h1, 2'h1);
		boot(4'h3, 2'h1, 6, 8, 2, 3'h1, 2'h2);
		boot(4'h4, 2'h3, 6, 16, 2, 3'h1, 2'h3);
		boot(4'h5, 2'h0, 18, 0, 2, 3'h2, 2'h0);
		boot(4'h6, 2'h1, 18, 8, 2, 3'h2, 2'h1);
		wake(36);
		boot(4'h7, 2'h2, 18, 16, 2, 3'h2, 2'h2);
		boot(4'h8, 2'h3, 6, 8, 2, 3'h2, 2'h3);
		boot(4'h9, 2'h0, 1024, 8, 1, 3'h3, 2'h0);
		boot(4'h9, 2'h1, 1024, 16, 1, 3'h3, 2'h0);
		boot(4'h9, 2'h2, 32768, 16, 1, 3'h3, 2'h0);
		boot(4'h9, 2'h3, 32768, 16, 1, 3'h3, 2'h0);
		boot(4'h1, 2'h2, 6, 16, 2, 3'h1, 2'h0);
		axr(4'h0, 32'h000000a1, RESP_OKAY);
		axr(4'h4, 32'h000061a1, RESP_OKAY);
		axw(4'h0, 32'h00000000, RESP_OKAY);
		axr(4'h0, 32'h00000000, RESP_OKAY);
		axw(4'h0, 32'hffffffff, RESP_OKAY);
		axr(4'h0, 32'h000000ff, RESP_OKAY);
		chk(clk_select.trim_value, 8'hff);
		axw(4'h4, 32'h00000000, RESP_SLVERR);
		axr(4'h8, 32'h00000000, RESP_SLVERR);
		// Codes above the low-frequency crystal decode as the crystal kind.
		@(posedge aclk);
		aresetn <= 1'b0;
		fuses <= '{4'hf, 2'h0, 1'b1};
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		#1 chk(clk_select.kind, KIND_CRYSTAL);
		chk(core_clock_en, 1'b0);
		// Factory trim is back in place before any nonvolatile write could follow.
		boot(4'h1, 2'h2, 6, 16, 2, 3'h1, 2'h0);
		results();
	end
endmodule : clock_source_startup_select_tb

`default_nettype wire

// [testbench/csss_asserts.sv]
`timescale 1ns/1ns
`default_nettype none

module csss_asserts (
	input wire logic                 aclk,
	input wire logic                 aresetn,
	input wire logic                 s_axi_arvalid,
	input wire logic                 s_axi_arready,
	input wire logic                 s_axi_rvalid,
	input wire csss_pkg::csss_fuse_s fuses,
	input wire logic [7:0]           factory_calibration,
	input wire logic                 rc_osc_tick,
	input wire logic                 deep_sleep,
	input wire csss_pkg::csss_clk_s  clk_select,
	input wire logic                 core_clock_en,
	input wire logic                 nvm_timing_tick
);
	import csss_pkg::*;

	logic [3:0] sel;

	// Fuses are raw levels, so codes compare directly.
	assign sel = fuses.clock_source_select_fuses;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_boot;
		$rose(aresetn);
	endsequence
	sequence s_held;
		!core_clock_en [*5];
	endsequence

	a_trim_cal: assert property (s_boot |-> clk_select.trim_value == $past(factory_calibration))
		else $error("trim not loaded from calibration");
	a_core_gated: assert property (s_boot |-> s_held)
		else $error("core clock released too early");
	a_nvm_tick: assert property (nvm_timing_tick == $past(rc_osc_tick))
		else $error("memory timing tick does not follow oscillator");
	a_sleep_stop: assert property (core_clock_en && deep_sleep |=> !core_clock_en)
		else $error("core clock not stopped on sleep");
	a_lf_kind: assert property (sel == 4'h9 |-> clk_select.kind == KIND_LF_CRYSTAL)
		else $error("low-frequency crystal not selected");
	a_ext_clk: assert property (sel == 4'h0 |-> clk_select.kind == KIND_EXT_CLOCK)
		else $error("external clock not selected");
	a_int_rc: assert property (sel inside {[1:4]} |->
		clk_select.kind == KIND_INT_RC && clk_select.band == sel[1:0] - 2'h1)
		else $error("internal oscillator frequency wrong");
	a_ext_rc: assert property (sel inside {[5:8]} |->
		clk_select.kind == KIND_EXT_RC && clk_select.band == sel[1:0] - 2'h1)
		else $error("external RC band wrong");
	a_xtal_kind: assert property (sel >= 4'ha |-> clk_select.kind == KIND_CRYSTAL)
		else $error("crystal codes not decoded");
	a_rd_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
endmodule : csss_asserts

bind csss_top csss_asserts chk_u (.aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .fuses(fuses),
	.factory_calibration(factory_calibration), .rc_osc_tick(rc_osc_tick), .deep_sleep(deep_sleep),
	.clk_select(clk_select), .core_clock_en(core_clock_en), .nvm_timing_tick(nvm_timing_tick));

`default_nettype wire

// [testbench/csss_src_model.sv]
`timescale 1ns/1ns
`default_nettype none

module csss_src_model (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic [3:0] sp,
	output logic            src_osc_tick,
	output logic            wdt_osc_tick,
	output logic            rc_osc_tick
);
	logic [3:0] sc;
	logic [1:0] wc;
	logic [1:0] rc;

	// The watchdog rate differs from the source rate, so a count taken from the wrong one shows.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sc <= 4'h0;
			wc <= 2'h0;
			rc <= 2'h0;
		end else begin
			sc <= (sc + 4'h1 >= sp) ? 4'h0 : sc + 4'h1;
			wc <= (wc == 2'h2) ? 2'h0 : wc + 2'h1;
			rc <= rc + 2'h1;
		end
	end

	// The source rate is changed only while reset is held, and all ticks stop in reset.
	assign src_osc_tick = aresetn && (sc == sp - 4'h1);
	assign wdt_osc_tick = aresetn && (wc == 2'h2);
	assign rc_osc_tick  = aresetn && (rc == 2'h3);
endmodule : csss_src_model

`default_nettype wire
